// ---- verilog/e1_alarm_consts.svh ----
// Contract
// - Sixteen all-zero slot-16 octets raise loss
// - Any non-zero slot-16 octet drops loss
// - Two periods under four zeros raise AIS16
// - Period above three zeros drops AIS16
// - Three consecutive Y ones raise multiframe alarm
// - One Y zero drops multiframe alarm
// - Mode zero: sparse window, unaligned raises AIS
// - Mode zero: window above two zeros drops
// - Mode one: two windows raise or drop
// - Mode zero: four A ones raise far-end
// - Mode one: one A raises; zero drops
// - Loss or hold of alignment 100ms toggles
// - Slot-16 state changes set change bits
// - Change bits clear only by writing one
// - Enable bits gate change bits onto irq, reset zero
// - Other state changes set change bits
// - Criterion select bits writable, reset zero
`ifndef E1_ALARM_CONSTS_SVH
`define E1_ALARM_CONSTS_SVH
`define IDX_LIVE 12'h00b9
`define IDX_EN 12'h00ba
`define IDX_LATCH 12'h00bb
`define IDX_CRIT 12'h00bc
`define ADDR_LIVE 12'h02e4
`define ADDR_EN 12'h02e8
`define ADDR_LATCH 12'h02ec
`define ADDR_CRIT 12'h02f0
`define BIT_RED 0
`define BIT_FAR 1
`define BIT_AIS 2
`define BIT_RMAI 3
`define BIT_AIS16 4
`define BIT_LOS16 5
`define BIT_FAR_SEL 0
`define BIT_AIS_SEL 1
`define RST_VEC 6'h00
`define LOS16_RUN 5'h10
`define AIS16_LIMIT 8'h04
`define AIS16_FRAMES 4'hf
`define Y_RUN 2'h3
`define A_RUN 3'h4
`define AIS_WIN_LAST 9'h1ff
`define AIS_ZERO_LIMIT 2'h3
`define RED_TIME_MS 100
`define CLK_FREQ_MHZ 100
`endif

// ---- verilog/e1_alarm_pkg.sv ----
`default_nettype none
package e1_alarm_pkg;
    typedef logic [5:0] alarm_vec_t;
    typedef logic [11:0] apb_addr_t;
    typedef logic [31:0] apb_data_t;
endpackage
`default_nettype wire

// ---- verilog/e1_receive_alarm_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "e1_alarm_consts.svh"
module e1_receive_alarm_monitor #(
    parameter int unsigned RED_CYCLES = `RED_TIME_MS * 1000 * `CLK_FREQ_MHZ
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire e1_alarm_pkg::apb_addr_t paddr,
    input wire e1_alarm_pkg::apb_data_t pwdata,
    output logic pready,
    output e1_alarm_pkg::apb_data_t prdata,
    output logic pslverr,
    input wire logic frame_aligned,
    input wire logic cas_aligned,
    input wire logic line_bit_valid,
    input wire logic line_bit,
    input wire logic slot16_valid,
    input wire logic [7:0] slot16_octet,
    input wire logic y_bit_valid,
    input wire logic y_bit,
    input wire logic a_bit_valid,
    input wire logic a_bit,
    output e1_alarm_pkg::alarm_vec_t alarm_live_state,
    output logic irq
);
    import e1_alarm_pkg::*;

    alarm_vec_t alarm_irq_enable;
    alarm_vec_t alarm_change_latch;
    alarm_vec_t prev_live;
    logic all_ones_criterion_sel;
    logic far_end_criterion_sel;
    logic slot16_zero_loss_state;
    logic slot16_all_ones_state;
    logic remote_multiframe_alarm_state;
    logic all_ones_state;
    logic far_end_alarm_state;
    logic persistent_frame_loss_state;

    // Bus decode
    wire hit_live = (paddr == `ADDR_LIVE);
    wire hit_en = (paddr == `ADDR_EN);
    wire hit_latch = (paddr == `ADDR_LATCH);
    wire hit_crit = (paddr == `ADDR_CRIT);
    wire mapped = hit_live | hit_en | hit_latch | hit_crit;
    wire setup = ce & psel & ~penable;
    wire access = ce & psel & penable;
    wire wr = access & pwrite & mapped;
    wire wr_en = wr & hit_en;
    wire wr_latch = wr & hit_latch;
    wire wr_crit = wr & hit_crit;
    // Frozen clock enable must stall the bus too, or a write is lost
    assign pready = ce;
    assign pslverr = access & ~mapped;

    wire [31:0] rd_live = {26'h000_0000, alarm_live_state};
    wire [31:0] rd_en = {26'h000_0000, alarm_irq_enable};
    wire [31:0] rd_latch = {26'h000_0000, alarm_change_latch};
    wire [31:0] rd_crit = {30'h0000_0000, all_ones_criterion_sel, far_end_criterion_sel};
    wire [31:0] next_prdata = hit_live ? rd_live :
                              hit_en ? rd_en :
                              hit_latch ? rd_latch :
                              hit_crit ? rd_crit : 32'h0000_0000;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (setup)
            prdata <= next_prdata;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            alarm_irq_enable <= `RST_VEC;
            all_ones_criterion_sel <= 1'b0;
            far_end_criterion_sel <= 1'b0;
        end
        else
        begin
            if (wr_en)
                alarm_irq_enable <= pwdata[5:0];
            if (wr_crit)
            begin
                all_ones_criterion_sel <= pwdata[`BIT_AIS_SEL];
                far_end_criterion_sel <= pwdata[`BIT_FAR_SEL];
            end
        end
    end

    // Slot-16 all-zero run
    logic [4:0] los16_run;
    wire slot16_ok = ce & slot16_valid & frame_aligned;
    wire slot16_zero = (slot16_octet == 8'h00);
    wire [4:0] next_los16_run = slot16_zero ?
        ((los16_run == `LOS16_RUN) ? los16_run : los16_run + 5'h01) : 5'h00;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            los16_run <= 5'h00;
            slot16_zero_loss_state <= 1'b0;
        end
        else if (slot16_ok)
        begin
            los16_run <= next_los16_run;
            slot16_zero_loss_state <= (next_los16_run == `LOS16_RUN);
        end
    end

    // Slot-16 zero count per 16-frame period
    logic [3:0] ais16_frame;
    logic [7:0] ais16_zeros;
    logic ais16_prev_low;
    logic [3:0] octet_zeros;
    always_comb
    begin
        octet_zeros = 4'h0;
        for (int i = 0; i < 8; i++)
            octet_zeros = octet_zeros + {3'h0, ~slot16_octet[i]};
    end
    wire [7:0] ais16_sum = ais16_zeros + {4'h0, octet_zeros};
    wire ais16_end = (ais16_frame == `AIS16_FRAMES);
    wire ais16_low = (ais16_sum < `AIS16_LIMIT);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ais16_frame <= 4'h0;
            ais16_zeros <= 8'h00;
            ais16_prev_low <= 1'b0;
            slot16_all_ones_state <= 1'b0;
        end
        else if (slot16_ok)
        begin
            ais16_frame <= ais16_frame + 4'h1;
            ais16_zeros <= ais16_end ? 8'h00 : ais16_sum;
            if (ais16_end)
            begin
                ais16_prev_low <= ais16_low;
                if (ais16_low && ais16_prev_low)
                    slot16_all_ones_state <= 1'b1;
                else if (!ais16_low)
                    slot16_all_ones_state <= 1'b0;
            end
        end
    end

    // Y bit run in CAS multiframe
    logic [1:0] y_run;
    wire y_ok = ce & y_bit_valid & cas_aligned;
    wire [1:0] next_y_run = (y_run == `Y_RUN) ? y_run : y_run + 2'h1;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            y_run <= 2'h0;
            remote_multiframe_alarm_state <= 1'b0;
        end
        else if (y_ok)
        begin
            if (y_bit)
            begin
                y_run <= next_y_run;
                if (next_y_run == `Y_RUN)
                    remote_multiframe_alarm_state <= 1'b1;
            end
            else
            begin
                y_run <= 2'h0;
                remote_multiframe_alarm_state <= 1'b0;
            end
        end
    end

    // All-ones over fixed 512-bit windows
    logic [8:0] win_bit;
    logic [1:0] win_zeros;
    logic win_prev_few;
    wire bit_ok = ce & line_bit_valid;
    wire win_end = (win_bit == `AIS_WIN_LAST);
    wire [1:0] win_sum = (!line_bit && win_zeros != `AIS_ZERO_LIMIT) ?
        win_zeros + 2'h1 : win_zeros;
    // Saturating at three is enough: only fewer than three matters
    wire win_few = (win_sum != `AIS_ZERO_LIMIT);
    wire ais_set0 = win_few & ~frame_aligned;
    wire ais_set1 = win_few & win_prev_few;
    wire ais_clr1 = ~win_few & ~win_prev_few;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            win_bit <= 9'h000;
            win_zeros <= 2'h0;
            win_prev_few <= 1'b0;
            all_ones_state <= 1'b0;
        end
        else if (bit_ok)
        begin
            win_bit <= win_bit + 9'h001;
            win_zeros <= win_end ? 2'h0 : win_sum;
            if (win_end)
            begin
                win_prev_few <= win_few;
                if (!all_ones_criterion_sel)
                begin
                    if (ais_set0)
                        all_ones_state <= 1'b1;
                    else if (!win_few)
                        all_ones_state <= 1'b0;
                end
                else
                begin
                    if (ais_set1)
                        all_ones_state <= 1'b1;
                    else if (ais_clr1)
                        all_ones_state <= 1'b0;
                end
            end
        end
    end

    // A bit run in basic frames
    logic [2:0] a_run;
    wire a_ok = ce & a_bit_valid & frame_aligned;
    wire [2:0] next_a_run = (a_run == `A_RUN) ? a_run : a_run + 3'h1;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            a_run <= 3'h0;
            far_end_alarm_state <= 1'b0;
        end
        else if (a_ok)
        begin
            if (a_bit)
            begin
                a_run <= next_a_run;
                if (far_end_criterion_sel || next_a_run == `A_RUN)
                    far_end_alarm_state <= 1'b1;
            end
            else
            begin
                a_run <= 3'h0;
                far_end_alarm_state <= 1'b0;
            end
        end
    end

    // Persistence timer; restarts whenever alignment flickers
    logic [23:0] red_cnt;
    wire red_pending = frame_aligned ~^ persistent_frame_loss_state;
    wire red_done = (red_cnt == 24'(RED_CYCLES - 1));

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            red_cnt <= 24'h00_0000;
            persistent_frame_loss_state <= 1'b0;
        end
        else if (ce)
        begin
            if (!red_pending || red_done)
                red_cnt <= 24'h00_0000;
            else
                red_cnt <= red_cnt + 24'h00_0001;
            if (red_pending && red_done)
                persistent_frame_loss_state <= ~persistent_frame_loss_state;
        end
    end

    assign alarm_live_state = {slot16_zero_loss_state, slot16_all_ones_state,
                               remote_multiframe_alarm_state, all_ones_state,
                               far_end_alarm_state, persistent_frame_loss_state};

    // Change latch; a new edge beats a simultaneous clear
    wire [5:0] edges = alarm_live_state ^ prev_live;
    wire [5:0] clr = wr_latch ? pwdata[5:0] : 6'h00;
    wire [5:0] next_latch = (alarm_change_latch & ~clr) | edges;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            prev_live <= `RST_VEC;
            alarm_change_latch <= `RST_VEC;
        end
        else if (ce)
        begin
            prev_live <= alarm_live_state;
            alarm_change_latch <= next_latch;
        end
    end

    assign irq = |(alarm_change_latch & alarm_irq_enable);

    sequence s_en_zero_write;
        wr_en && pwdata[5:0] == 6'h00;
    endsequence

    sequence s_no_latch_write;
        ce && !wr_latch;
    endsequence

    chk_los_raise: assert property (@(posedge clk_sys) disable iff (rst)
        slot16_ok && slot16_zero && los16_run == 5'h0f |=> slot16_zero_loss_state)
        else $error("slot16 loss not raised after sixteen zero octets");

    chk_los_drop: assert property (@(posedge clk_sys) disable iff (rst)
        slot16_ok && !slot16_zero |=> !slot16_zero_loss_state)
        else $error("slot16 loss held after non-zero octet");

    chk_ais16_clear: assert property (@(posedge clk_sys) disable iff (rst)
        slot16_ok && ais16_end && !ais16_low |=> !slot16_all_ones_state)
        else $error("slot16 AIS held after busy period");

    chk_y_raise: assert property (@(posedge clk_sys) disable iff (rst)
        y_ok && y_bit && y_run == 2'h2 |=> remote_multiframe_alarm_state)
        else $error("multiframe alarm not raised after three Y ones");

    chk_y_drop: assert property (@(posedge clk_sys) disable iff (rst)
        y_ok && !y_bit |=> !remote_multiframe_alarm_state)
        else $error("multiframe alarm held after Y zero");

    chk_ais_raise: assert property (@(posedge clk_sys) disable iff (rst)
        bit_ok && win_end && win_few && !frame_aligned && !all_ones_criterion_sel
        |=> all_ones_state)
        else $error("AIS not raised on sparse unaligned window");

    chk_far_single: assert property (@(posedge clk_sys) disable iff (rst)
        a_ok && a_bit && far_end_criterion_sel |=> far_end_alarm_state)
        else $error("far-end alarm not raised on single A one");

    chk_red_timer: assert property (@(posedge clk_sys) disable iff (rst)
        ce && red_pending && red_done
        |=> persistent_frame_loss_state != $past(persistent_frame_loss_state))
        else $error("persistent loss state did not toggle at timeout");

    chk_latch_edge: assert property (@(posedge clk_sys) disable iff (rst)
        ce && alarm_live_state != prev_live
        |=> (($past(edges) & ~alarm_change_latch) == 6'h00))
        else $error("live state change not latched");

    chk_latch_hold: assert property (@(posedge clk_sys) disable iff (rst)
        s_no_latch_write |=> ($past(alarm_change_latch) & ~alarm_change_latch) == 6'h00)
        else $error("change bit cleared without a write");

    chk_irq_masked: assert property (@(posedge clk_sys) disable iff (rst)
        s_en_zero_write ##1 1'b1 |-> !irq)
        else $error("interrupt asserted with all enables clear");

endmodule // e1_receive_alarm_monitor
`default_nettype wire

// ---- tb/e1_far_end_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module e1_far_end_model (
    input wire logic clk_sys,
    output logic frame_aligned,
    output logic cas_aligned,
    output logic line_bit_valid,
    output logic line_bit,
    output logic slot16_valid,
    output logic [7:0] slot16_octet,
    output logic y_bit_valid,
    output logic y_bit,
    output logic a_bit_valid,
    output logic a_bit
);
    initial
    begin
        frame_aligned = 1'b1;
        cas_aligned = 1'b1;
        {line_bit_valid, slot16_valid, y_bit_valid, a_bit_valid} = 4'h0;
        {line_bit, y_bit, a_bit, slot16_octet} = 11'h000;
    end

    // Kind 0 slot16 octet, 1 Y bit, 2 A bit, 3 line bit
    task automatic send(input int kind, input logic [7:0] v);
        @(posedge clk_sys);
        {line_bit_valid, a_bit_valid, y_bit_valid, slot16_valid} <= 4'h1 << kind;
        slot16_octet <= v;
        {line_bit, y_bit, a_bit} <= {3{v[0]}};
        @(posedge clk_sys);
        {line_bit_valid, slot16_valid, y_bit_valid, a_bit_valid} <= 4'h0;
        // Stale data must not look valid once the strobe is gone
        slot16_octet <= ~v;
        {line_bit, y_bit, a_bit} <= {3{~v[0]}};
    endtask

    task automatic align(input logic f);
        @(posedge clk_sys);
        frame_aligned <= f;
    endtask

    task automatic cas_align(input logic f);
        @(posedge clk_sys);
        cas_aligned <= f;
    endtask
endmodule // e1_far_end_model
`default_nettype wire

// ---- tb/e1_receive_alarm_monitor_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "e1_alarm_consts.svh"
module e1_receive_alarm_monitor_tb;
    import e1_alarm_pkg::*;
    localparam apb_addr_t a_live = `ADDR_LIVE;
    localparam apb_addr_t a_en = `ADDR_EN;
    localparam apb_addr_t a_lat = `ADDR_LATCH;
    localparam apb_addr_t a_crit = `ADDR_CRIT;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    apb_addr_t paddr = 12'h000;
    apb_data_t pwdata = 32'h0000_0000;
    apb_data_t prdata;
    apb_data_t rd;
    logic pready, pslverr, irq, err;
    logic frame_aligned, cas_aligned, line_bit_valid, line_bit, slot16_valid;
    logic y_bit_valid, y_bit, a_bit_valid, a_bit;
    logic [7:0] slot16_octet;
    alarm_vec_t alarm_live_state;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;

    always #5 clk_sys = ~clk_sys;

    // Short persistence count keeps the run brief
    e1_receive_alarm_monitor #(.RED_CYCLES(20)) dut (.clk_sys, .rst, .ce, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .frame_aligned, .cas_aligned,
        .line_bit_valid, .line_bit, .slot16_valid, .slot16_octet, .y_bit_valid, .y_bit,
        .a_bit_valid, .a_bit, .alarm_live_state, .irq);
    e1_far_end_model far (.clk_sys, .frame_aligned, .cas_aligned, .line_bit_valid,
        .line_bit, .slot16_valid, .slot16_octet, .y_bit_valid, .y_bit, .a_bit_valid, .a_bit);

    task automatic finish_test();
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic chk(input apb_data_t seen, input apb_data_t exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input apb_addr_t a, input apb_data_t d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input apb_addr_t a, input apb_data_t exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // Sample away from the edge that updates enable and latch bits
    task automatic irqc(input logic exp);
        @(negedge clk_sys);
        chk(irq, exp);
    endtask

    task automatic t_reset();
        rdc(a_en, 6'h00);
        rdc(a_lat, 6'h00);
        rdc(a_crit, 6'h00);
        apb(1'b1, a_crit, 32'hffff_ffff);
        rdc(a_crit, 6'h03);
        apb(1'b1, a_crit, 32'h0000_0000);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk({rd[30:0], err}, 1'h1);
    endtask

    task automatic t_slot16();
        repeat (15) far.send(0, 8'h00);
        rdc(a_live, 6'h00);
        far.send(0, 8'h00);
        rdc(a_live, 6'h20);
        rdc(a_lat, 6'h20);
        irqc(1'b0);
        apb(1'b1, a_en, 32'h0000_0020);
        irqc(1'b1);
        apb(1'b1, a_lat, 32'h0000_001f);
        rdc(a_lat, 6'h20);
        apb(1'b1, a_lat, 32'h0000_0020);
        rdc(a_lat, 6'h00);
        irqc(1'b0);
        far.send(0, 8'hff);
        rdc(a_live, 6'h00);
        repeat (30) far.send(0, 8'hff);
        rdc(a_live, 6'h00);
        far.send(0, 8'hff);
        rdc(a_live, 6'h10);
        repeat (16) far.send(0, 8'h0f);
        rdc(a_live, 6'h00);
        rdc(a_lat, 6'h30);
        irqc(1'b1);
        apb(1'b1, a_en, 32'h0000_0000);
        irqc(1'b0);
        apb(1'b1, a_lat, 32'h0000_0030);
    endtask

    task automatic t_bits();
        repeat (3) far.send(2, 8'h01);
        rdc(a_live, 6'h00);
        far.send(2, 8'h01);
        rdc(a_live, 6'h02);
        far.send(2, 8'h00);
        rdc(a_live, 6'h00);
        apb(1'b1, a_crit, 32'h0000_0001);
        // Frozen clock enable: the strobe must be ignored
        ce <= 1'b0;
        far.send(2, 8'h01);
        chk(pready, 1'h0);
        ce <= 1'b1;
        rdc(a_live, 6'h00);
        far.send(2, 8'h01);
        rdc(a_live, 6'h02);
        far.send(2, 8'h00);
        // Y ones without multiframe alignment must not count
        far.cas_align(1'b0);
        repeat (3) far.send(1, 8'h01);
        far.cas_align(1'b1);
        repeat (2) far.send(1, 8'h01);
        rdc(a_live, 6'h00);
        far.send(1, 8'h01);
        rdc(a_live, 6'h08);
        far.send(1, 8'h00);
        rdc(a_live, 6'h00);
        rdc(a_lat, 6'h0a);
        apb(1'b1, a_lat, 32'h0000_000a);
        apb(1'b1, a_crit, 32'h0000_0000);
    endtask

    task automatic t_red();
        far.align(1'b0);
        repeat (8) @(posedge clk_sys);
        rdc(a_live, 6'h00);
        repeat (15) @(posedge clk_sys);
        rdc(a_live, 6'h01);
        chk(alarm_live_state, 6'h01);
        far.align(1'b1);
        repeat (8) @(posedge clk_sys);
        rdc(a_live, 6'h01);
        repeat (15) @(posedge clk_sys);
        rdc(a_live, 6'h00);
        rdc(a_lat, 6'h01);
        apb(1'b1, a_lat, 32'h0000_0001);
    endtask

    // One fixed window of line bits, zeros first
    task automatic win(input int zeros, input apb_data_t exp);
        for (int i = 0; i < 512; i++)
            far.send(3, {7'h00, i >= zeros});
        rdc(a_live, exp);
    endtask

    task automatic t_ais();
        win(0, 6'h00);
        far.align(1'b0);
        win(0, 6'h05);
        win(2, 6'h05);
        win(3, 6'h01);
        apb(1'b1, a_crit, 32'h0000_0002);
        win(0, 6'h01);
        win(0, 6'h05);
        win(3, 6'h05);
        win(3, 6'h01);
        rdc(a_lat, 6'h05);
        far.align(1'b1);
    endtask

    // Reset in mid-run with enables set and change bits pending
    task automatic t_rst();
        apb(1'b1, a_en, 32'h0000_003f);
        irqc(1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(a_en, 6'h00);
        rdc(a_crit, 6'h00);
        rdc(a_lat, 6'h00);
        irqc(1'b0);
    endtask

    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_slot16();
        t_bits();
        t_red();
        t_ais();
        t_rst();
        finish_test();
    end
endmodule // e1_receive_alarm_monitor_tb
`default_nettype wire
